// >>> shared/char_status_pkg.sv
// Package: register offsets, field positions and constants of the channel status bank
package char_status_pkg;

    // ------------------------------------------------------------
    // Register byte offsets (word index printed, byte = 4 * index)
    // ------------------------------------------------------------
    localparam logic [7:0] EXCH_ACT_IDX = 8'h00;
    localparam logic [7:0] EXCH_FAIL_IDX = 8'h01;
    localparam logic [7:0] FAULT_IDX = 8'h02;
    localparam logic [7:0] PROTO_IDX = 8'h03;
    localparam logic [7:0] TX_ANOM_IDX = 8'h04;
    localparam logic [7:0] RX_ANOM_IDX = 8'h05;
    localparam logic [7:0] CMD_IDX = 8'h18;
    localparam logic [7:0] OUT_WORD_IDX = 8'h20;
    localparam logic [7:0] MODEM_IDX = 8'h21;
    localparam logic [7:0] ERROR_IDX = 8'h22;
    localparam logic [7:0] IRQ_STAT_IDX = 8'h23;
    localparam logic [7:0] IRQ_MASK_IDX = 8'h24;

    // ------------------------------------------------------------
    // Field positions and values
    // ------------------------------------------------------------
    localparam int CMD_CLR_BIT = 0;
    localparam int CMD_DTR_ON_BIT = 8;
    localparam int CMD_DTR_OFF_BIT = 9;
    localparam int HALT_BIT = 0;
    localparam int MODEM_DCD_BIT = 0;
    localparam int MODEM_CTS_BIT = 2;
    localparam int MODEM_DSR_BIT = 3;
    localparam logic [15:0] RESTART_KEY = 16'hdead;
    localparam logic [7:0] CHAR_MODE_ID = 8'h03;
    localparam logic [15:0] WORD_RST = 16'h0000;
    localparam int RESTART_CYCLES = 16;

    // Interrupt status bits
    localparam int IRQ_TX_ANOM = 0;
    localparam int IRQ_RX_ANOM = 1;
    localparam int IRQ_ERROR = 2;
    localparam int IRQ_HALT = 3;
    localparam int IRQ_WIDTH = 4;

endpackage

// >>> hw/char_status_bank.sv
// Status, counter and command register bank of one character-mode serial channel
// Operation
// - A readable word counts anomalies found in sent characters.
// - A separate readable word counts anomalies found in received characters.
// - Writing bit 0 of the command word as one clears both anomaly counters.
// - Writing the restart key to the output word triggers a full module restart.
// - A read-only error flag is one while the channel is in error.
// - The modem word shows DCD at bit 0, CTS at bit 2 and DSR at bit 3.
// - Each modem bit reads one while its line voltage is positive.
// - The activity word shows status read, command transfer and adjust flags.
// - The failure word flags failed status read, command and adjust transfers.
// - Fault bits 0 to 3 show no device, failed device, block missing, timeout.
// - Fault bits 4 to 7 show internal, config mismatch, PLC link, application.
// - The low byte of the protocol word reads the character mode code.
// - Command bits 8 and 9 set and reset the DTR output.
// - A rising edge of output word bit 0 halts all exchanges.
//
// Local design decisions: the Wishbone slave port and the register addresses.
`timescale 1ns/1ps

module char_status_bank (
    // Clock and reset
    input wire logic clk_i,
    input wire logic rst_i,
    // Wishbone slave
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic [7:0] wb_adr_i,
    input wire logic [3:0] wb_sel_i,
    input wire logic [31:0] wb_dat_i,
    output logic [31:0] wb_dat_o,
    output logic wb_ack_o,
    // Channel events from the serial engine
    input wire logic tx_anomaly_i,
    input wire logic rx_anomaly_i,
    input wire logic channel_fault_i,
    // Modem lines, high while voltage positive
    input wire logic dcd_i,
    input wire logic cts_i,
    input wire logic dsr_i,
    // Exchange engine state
    input wire logic status_read_active_i,
    input wire logic command_xfer_active_i,
    input wire logic adjust_xfer_active_i,
    input wire logic status_read_failed_i,
    input wire logic command_xfer_failed_i,
    input wire logic adjust_xfer_failed_i,
    // Channel faults
    input wire logic no_device_i,
    input wire logic device_failed_i,
    input wire logic terminal_block_missing_i,
    input wire logic timeout_exceeded_i,
    input wire logic internal_or_selftest_i,
    input wire logic config_mismatch_i,
    input wire logic plc_link_problem_i,
    input wire logic application_setting_error_i,
    // Channel controls
    output logic dtr_o,
    output logic halt_all_exchanges_o,
    output logic module_restart_o,
    output logic irq_o
);
    import char_status_pkg::*;

    // ------------------------------------------------------------
    // State
    // ------------------------------------------------------------
    typedef struct packed {
        logic [15:0] tx_count;
        logic [15:0] rx_count;
        logic [15:0] cmd_word;
        logic [15:0] out_word;
        logic dtr;
        logic halt;
        logic [4:0] restart_cnt;
        logic [IRQ_WIDTH-1:0] irq_stat;
        logic [IRQ_WIDTH-1:0] irq_mask;
        logic err_prev;
        logic ack;
        logic [31:0] rdata;
    } state_t;

    state_t cur;
    state_t next_cur;

    // Saturating increment, shared by both counters
    function automatic logic [15:0] bump(input logic [15:0] v, input logic ev);
        bump = (ev && v != 16'hffff) ? v + 16'h0001 : v;
    endfunction

    // Byte-lane merge of a 16-bit word
    function automatic logic [15:0] merge16(input logic [15:0] old, input logic [31:0] d,
                                            input logic [3:0] sel);
        merge16 = {sel[1] ? d[15:8] : old[15:8], sel[0] ? d[7:0] : old[7:0]};
    endfunction

    logic wr_req;
    logic rd_req;
    logic [7:0] widx;
    logic [15:0] modem_word;
    logic [15:0] act_word;
    logic [15:0] fail_word;
    logic [15:0] fault_word;
    logic [15:0] wval;
    logic [IRQ_WIDTH-1:0] irq_events;

    // ------------------------------------------------------------
    // Status words
    // ------------------------------------------------------------
    // Request decode; ack drops the cycle after it is given
    assign wr_req = wb_cyc_i && wb_stb_i && wb_we_i && !cur.ack;
    assign rd_req = wb_cyc_i && wb_stb_i && !wb_we_i && !cur.ack;
    assign widx = {2'b00, wb_adr_i[7:2]};

    // lines arrive already as positive-voltage levels
    always_comb begin
        modem_word = WORD_RST;
        modem_word[MODEM_DCD_BIT] = dcd_i;
        modem_word[MODEM_CTS_BIT] = cts_i;
        modem_word[MODEM_DSR_BIT] = dsr_i;
    end

    assign act_word = {13'h0000, adjust_xfer_active_i, command_xfer_active_i,
                       status_read_active_i};
    assign fail_word = {13'h0000, adjust_xfer_failed_i, command_xfer_failed_i,
                        status_read_failed_i};
    assign fault_word = {8'h00, application_setting_error_i, plc_link_problem_i,
                         config_mismatch_i, internal_or_selftest_i, timeout_exceeded_i,
                         terminal_block_missing_i, device_failed_i, no_device_i};

    // Events feeding sticky interrupt bits; halt edge joins later to avoid a comb loop
    assign irq_events = {1'b0, channel_fault_i && !cur.err_prev, rx_anomaly_i, tx_anomaly_i};

    // ------------------------------------------------------------
    // Next state
    // ------------------------------------------------------------
    always_comb begin
        next_cur = cur;
        wval = WORD_RST;
        next_cur.ack = wr_req || rd_req;
        next_cur.err_prev = channel_fault_i;
        next_cur.tx_count = bump(cur.tx_count, tx_anomaly_i);
        next_cur.rx_count = bump(cur.rx_count, rx_anomaly_i);
        if (cur.restart_cnt != 5'd0) begin
            next_cur.restart_cnt = cur.restart_cnt - 5'd1;
        end
        if (wr_req) begin
            unique case (widx)
                CMD_IDX: begin
                    // commands act only on an explicit bus write
                    wval = merge16(cur.cmd_word, wb_dat_i, wb_sel_i);
                    next_cur.cmd_word = wval;
                    // clear both counters, only on a freshly written bit
                    if (wb_sel_i[0] && wb_dat_i[CMD_CLR_BIT]) begin
                        next_cur.tx_count = WORD_RST;
                        next_cur.rx_count = WORD_RST;
                    end
                    // DTR set and reset, reset wins; stale stored bits never replay
                    if (wb_sel_i[1] && wb_dat_i[CMD_DTR_OFF_BIT]) begin
                        next_cur.dtr = 1'b0;
                    end else if (wb_sel_i[1] && wb_dat_i[CMD_DTR_ON_BIT]) begin
                        next_cur.dtr = 1'b1;
                    end
                end
                OUT_WORD_IDX: begin
                    wval = merge16(cur.out_word, wb_dat_i, wb_sel_i);
                    next_cur.out_word = wval;
                    // halt on rising edge of bit 0
                    if (wval[HALT_BIT] && !cur.out_word[HALT_BIT]) begin
                        next_cur.halt = 1'b1;
                    end else if (!wval[HALT_BIT]) begin
                        next_cur.halt = 1'b0;
                    end
                    if (wval == RESTART_KEY) begin
                        next_cur.restart_cnt = 5'(RESTART_CYCLES);
                    end
                end
                IRQ_STAT_IDX: begin
                    if (wb_sel_i[0]) begin
                        next_cur.irq_stat = cur.irq_stat & ~wb_dat_i[IRQ_WIDTH-1:0];
                    end
                end
                IRQ_MASK_IDX: begin
                    if (wb_sel_i[0]) begin
                        next_cur.irq_mask = wb_dat_i[IRQ_WIDTH-1:0];
                    end
                end
                default: begin
                end
            endcase
        end
        // Set wins over a same-cycle clear
        next_cur.irq_stat = next_cur.irq_stat | irq_events;
        next_cur.irq_stat[IRQ_HALT] = next_cur.irq_stat[IRQ_HALT] | (next_cur.halt && !cur.halt);
        next_cur.rdata = 32'h00000000;
        if (rd_req) begin
            unique case (widx)
                EXCH_ACT_IDX: next_cur.rdata = {16'h0000, act_word};
                EXCH_FAIL_IDX: next_cur.rdata = {16'h0000, fail_word};
                FAULT_IDX: next_cur.rdata = {16'h0000, fault_word};
                PROTO_IDX: next_cur.rdata = {24'h000000, CHAR_MODE_ID};
                TX_ANOM_IDX: next_cur.rdata = {16'h0000, cur.tx_count};
                RX_ANOM_IDX: next_cur.rdata = {16'h0000, cur.rx_count};
                CMD_IDX: next_cur.rdata = {16'h0000, cur.cmd_word};
                OUT_WORD_IDX: next_cur.rdata = {16'h0000, cur.out_word};
                MODEM_IDX: next_cur.rdata = {16'h0000, modem_word};
                ERROR_IDX: next_cur.rdata = {31'h00000000, channel_fault_i};
                IRQ_STAT_IDX: next_cur.rdata = {28'h0000000, cur.irq_stat};
                IRQ_MASK_IDX: next_cur.rdata = {28'h0000000, cur.irq_mask};
                default: next_cur.rdata = 32'h00000000;
            endcase
        end
    end

    // ------------------------------------------------------------
    // Registers
    // ------------------------------------------------------------
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            cur <= '0;
        end else begin
            cur <= next_cur;
        end
    end

    // Outputs
    assign wb_ack_o = cur.ack;
    assign wb_dat_o = cur.rdata;
    assign dtr_o = cur.dtr;
    assign halt_all_exchanges_o = cur.halt;
    assign module_restart_o = cur.restart_cnt != 5'd0;
    assign irq_o = |(cur.irq_stat & cur.irq_mask);

    // ------------------------------------------------------------
    // Assertions
    // ------------------------------------------------------------
    sequence s_clear_write;
        wr_req && widx == CMD_IDX && wb_sel_i[0] && wb_dat_i[CMD_CLR_BIT];
    endsequence

    property p_tx_count;
        @(posedge clk_i) disable iff (rst_i)
        tx_anomaly_i && !wr_req && cur.tx_count != 16'hffff
        |=> cur.tx_count == $past(cur.tx_count) + 16'h0001;
    endproperty
    a_tx_count: assert property (p_tx_count) else $error("tx count missed");

    property p_rx_count;
        @(posedge clk_i) disable iff (rst_i)
        rx_anomaly_i && !wr_req && cur.rx_count != 16'hffff
        |=> cur.rx_count == $past(cur.rx_count) + 16'h0001;
    endproperty
    a_rx_count: assert property (p_rx_count) else $error("rx count missed");

    property p_clear;
        @(posedge clk_i) disable iff (rst_i)
        s_clear_write |=> cur.tx_count == 16'h0000 && cur.rx_count == 16'h0000;
    endproperty
    a_clear: assert property (p_clear) else $error("counters not cleared");

    property p_restart;
        @(posedge clk_i) disable iff (rst_i)
        wr_req && widx == OUT_WORD_IDX && wb_sel_i[1:0] == 2'b11
        && wb_dat_i[15:0] == RESTART_KEY |=> module_restart_o [*8];
    endproperty
    a_restart: assert property (p_restart) else $error("restart not held");

    property p_error_read;
        @(posedge clk_i) disable iff (rst_i)
        rd_req && widx == ERROR_IDX |=> wb_dat_o[0] == $past(channel_fault_i) && wb_ack_o;
    endproperty
    a_error_read: assert property (p_error_read) else $error("error flag wrong");

    property p_proto;
        @(posedge clk_i) disable iff (rst_i)
        rd_req && widx == PROTO_IDX |=> wb_dat_o[7:0] == CHAR_MODE_ID;
    endproperty
    a_proto: assert property (p_proto) else $error("protocol id wrong");

    property p_dtr_off;
        @(posedge clk_i) disable iff (rst_i)
        wr_req && widx == CMD_IDX && wb_sel_i[1] && wb_dat_i[CMD_DTR_OFF_BIT] |=> !dtr_o;
    endproperty
    a_dtr_off: assert property (p_dtr_off) else $error("dtr not reset");

    property p_halt;
        @(posedge clk_i) disable iff (rst_i)
        $rose(cur.out_word[HALT_BIT]) |-> halt_all_exchanges_o;
    endproperty
    a_halt: assert property (p_halt) else $error("halt missing");

    property p_modem;
        @(posedge clk_i) disable iff (rst_i)
        rd_req && widx == MODEM_IDX |=> wb_dat_o[MODEM_CTS_BIT] == $past(cts_i);
    endproperty
    a_modem: assert property (p_modem) else $error("cts bit wrong");

    property p_dtr_on;
        @(posedge clk_i) disable iff (rst_i)
        wr_req && widx == CMD_IDX && wb_sel_i[1] && wb_dat_i[CMD_DTR_ON_BIT]
        && !wb_dat_i[CMD_DTR_OFF_BIT] |=> dtr_o;
    endproperty
    a_dtr_on: assert property (p_dtr_on) else $error("dtr not set");

    property p_modem_outer;
        @(posedge clk_i) disable iff (rst_i)
        rd_req && widx == MODEM_IDX
        |=> wb_dat_o[MODEM_DCD_BIT] == $past(dcd_i) && wb_dat_o[MODEM_DSR_BIT] == $past(dsr_i);
    endproperty
    a_modem_outer: assert property (p_modem_outer) else $error("dcd dsr wrong");

    property p_activity;
        @(posedge clk_i) disable iff (rst_i)
        rd_req && widx == EXCH_ACT_IDX |=> wb_dat_o[2:0]
        == $past({adjust_xfer_active_i, command_xfer_active_i, status_read_active_i});
    endproperty
    a_activity: assert property (p_activity) else $error("activity word wrong");

    property p_failure;
        @(posedge clk_i) disable iff (rst_i)
        rd_req && widx == EXCH_FAIL_IDX |=> wb_dat_o[2:0]
        == $past({adjust_xfer_failed_i, command_xfer_failed_i, status_read_failed_i});
    endproperty
    a_failure: assert property (p_failure) else $error("failure word wrong");

    sequence s_fault_read;
        rd_req && widx == FAULT_IDX;
    endsequence

    property p_fault_low;
        @(posedge clk_i) disable iff (rst_i)
        s_fault_read |=> wb_dat_o[3:0]
        == $past({timeout_exceeded_i, terminal_block_missing_i, device_failed_i, no_device_i});
    endproperty
    a_fault_low: assert property (p_fault_low) else $error("fault low bits wrong");

    property p_fault_high;
        @(posedge clk_i) disable iff (rst_i)
        s_fault_read |=> wb_dat_o[7:4] == $past({application_setting_error_i,
                                                plc_link_problem_i, config_mismatch_i,
                                                internal_or_selftest_i});
    endproperty
    a_fault_high: assert property (p_fault_high) else $error("fault high bits wrong");

endmodule // char_status_bank

// >>> test/channel_engine_model.sv
// Far-side channel engine model: anomaly events, line levels, exchange state
`timescale 1ns/1ps

module channel_engine_model (
    // Clock and reset
    input wire logic clk_i,
    input wire logic rst_i,
    // Requests from the bench
    input wire logic tx_fire_i,
    input wire logic rx_fire_i,
    input wire logic [17:0] level_i,
    // Reaction to the bank
    input wire logic halt_i,
    // Lines into the bank
    output logic tx_anomaly_o,
    output logic rx_anomaly_o,
    output logic [17:0] level_o
);
    // Registered so each requested cycle is one clean event
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            tx_anomaly_o <= 1'b0;
            rx_anomaly_o <= 1'b0;
            level_o <= 18'h0;
        end else begin
            tx_anomaly_o <= tx_fire_i;
            rx_anomaly_o <= rx_fire_i;
            level_o <= level_i;
            // A halted engine runs no exchanges, so activity drops
            if (halt_i) begin
                level_o[6:4] <= 3'h0;
            end
        end
    end
endmodule // channel_engine_model

// >>> test/tb_top.sv
// Testbench: register access scenarios for the channel status bank
`timescale 1ns/1ps

module tb_top;
    import char_status_pkg::*;

    // ------------------------------------------------------------
    // Signals and instances
    // ------------------------------------------------------------
    logic clk_i = 1'b0;
    logic rst_i = 1'b1;
    logic wb_cyc_i = 1'b0;
    logic wb_stb_i = 1'b0;
    logic wb_we_i = 1'b0;
    logic [7:0] wb_adr_i = 8'h00;
    logic [3:0] wb_sel_i = 4'h0;
    logic [31:0] wb_dat_i = 32'h0;
    logic [31:0] wb_dat_o;
    logic wb_ack_o, dtr_o, halt_o, restart_o, irq_o, tx_anom, rx_anom;
    logic tx_fire = 1'b0;
    logic rx_fire = 1'b0;
    logic [17:0] lv = 18'h0;
    logic [17:0] lvo;
    logic [31:0] rd;
    int errors = 0;
    int cmp_count = 0;
    int rst_cnt = 0;

    initial forever #5 clk_i = ~clk_i;

    // Level map: 0 error, 3:1 dcd/cts/dsr, 6:4 activity, 9:7 failure, 17:10 faults
    channel_engine_model model (.clk_i(clk_i), .rst_i(rst_i), .tx_fire_i(tx_fire),
        .rx_fire_i(rx_fire), .level_i(lv), .halt_i(halt_o), .tx_anomaly_o(tx_anom),
        .rx_anomaly_o(rx_anom), .level_o(lvo));

    char_status_bank dut (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc_i),
        .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i),
        .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o),
        .tx_anomaly_i(tx_anom), .rx_anomaly_i(rx_anom), .channel_fault_i(lvo[0]),
        .dcd_i(lvo[1]), .cts_i(lvo[2]), .dsr_i(lvo[3]), .status_read_active_i(lvo[4]),
        .command_xfer_active_i(lvo[5]), .adjust_xfer_active_i(lvo[6]),
        .status_read_failed_i(lvo[7]), .command_xfer_failed_i(lvo[8]),
        .adjust_xfer_failed_i(lvo[9]), .no_device_i(lvo[10]), .device_failed_i(lvo[11]),
        .terminal_block_missing_i(lvo[12]), .timeout_exceeded_i(lvo[13]),
        .internal_or_selftest_i(lvo[14]), .config_mismatch_i(lvo[15]),
        .plc_link_problem_i(lvo[16]), .application_setting_error_i(lvo[17]),
        .dtr_o(dtr_o), .halt_all_exchanges_o(halt_o), .module_restart_o(restart_o),
        .irq_o(irq_o));

    // Restart pulse length seen at the pin
    always @(posedge clk_i) if (restart_o === 1'b1) rst_cnt <= rst_cnt + 1;

    // ------------------------------------------------------------
    // Tasks
    // ------------------------------------------------------------
    task automatic stop_test();
        $display("Counts: %0d compares, %0d mismatches", cmp_count, errors);
        if (errors == 0 && cmp_count > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask

    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        cmp_count++;
        if (seen !== exp) begin
            errors++;
            $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask

    task automatic wb(input logic we, input logic [7:0] idx, input logic [15:0] wd);
        int k;
        k = 0;
        @(posedge clk_i);
        wb_cyc_i <= 1'b1;
        wb_stb_i <= 1'b1;
        wb_we_i <= we;
        wb_adr_i <= {idx[5:0], 2'b00};
        wb_sel_i <= 4'h3;
        wb_dat_i <= {16'h0, wd};
        do begin
            @(posedge clk_i);
            k++;
        end while (wb_ack_o !== 1'b1 && k < 20);
        rd = wb_dat_o;
        wb_cyc_i <= 1'b0;
        wb_stb_i <= 1'b0;
        wb_we_i <= 1'b0;
        if (wb_ack_o !== 1'b1) begin
            errors++;
            stop_test();
        end
    endtask

    // Holding a request for cnt edges gives cnt event cycles
    task automatic fire(input logic a, input logic b, input int cnt);
        @(posedge clk_i);
        tx_fire <= a;
        rx_fire <= b;
        repeat (cnt) @(posedge clk_i);
        tx_fire <= 1'b0;
        rx_fire <= 1'b0;
        repeat (4) @(posedge clk_i);
    endtask

    task automatic set_lv(input logic [17:0] v);
        @(posedge clk_i);
        lv <= v;
        repeat (4) @(posedge clk_i);
    endtask

    // ------------------------------------------------------------
    // Main sequence
    // ------------------------------------------------------------
    initial begin
        repeat (16) @(posedge clk_i);
        rst_i <= 1'b0;
        wb(0, PROTO_IDX, 0);
        check(rd[7:0], CHAR_MODE_ID);
        check({dtr_o, halt_o, restart_o, irq_o}, 4'h0);
        $display("Test reset done");
        fire(1, 1, 3);
        fire(0, 1, 2);
        wb(0, TX_ANOM_IDX, 0);
        check(rd, 32'h3);
        wb(0, RX_ANOM_IDX, 0);
        check(rd, 32'h5);
        wb(1, TX_ANOM_IDX, 16'h1234);
        wb(0, TX_ANOM_IDX, 0);
        check(rd, 32'h3);
        wb(1, CMD_IDX, 16'h0001);
        wb(0, TX_ANOM_IDX, 0);
        check(rd, 32'h0);
        wb(0, RX_ANOM_IDX, 0);
        check(rd, 32'h0);
        wb(0, 8'h10, 0);
        check(rd, 32'h0);
        $display("Test counters done");
        wb(1, IRQ_STAT_IDX, 16'h000f);
        fire(1, 0, 1);
        wb(0, IRQ_STAT_IDX, 0);
        check(rd, 32'h1);
        check(irq_o, 1'b0);
        wb(1, IRQ_MASK_IDX, 16'h0001);
        repeat (2) @(posedge clk_i);
        check(irq_o, 1'b1);
        wb(1, IRQ_STAT_IDX, 16'h0001);
        repeat (2) @(posedge clk_i);
        check(irq_o, 1'b0);
        $display("Test interrupt done");
        for (int i = 0; i < 8; i++) begin
            set_lv({14'h0, i[2:0], 1'b0});
            wb(0, MODEM_IDX, 0);
            check(rd[3:0], {i[2], i[1], 1'b0, i[0]});
        end
        for (int k = 0; k < 8; k++) begin
            set_lv(18'h1 << (10 + k));
            wb(0, FAULT_IDX, 0);
            check(rd[15:0], 16'h1 << k);
            if (k < 3) begin
                set_lv(18'h1 << (4 + k));
                wb(0, EXCH_ACT_IDX, 0);
                check(rd[15:0], 16'h1 << k);
                set_lv(18'h1 << (7 + k));
                wb(0, EXCH_FAIL_IDX, 0);
                check(rd[15:0], 16'h1 << k);
            end
        end
        set_lv(18'h1);
        wb(0, ERROR_IDX, 0);
        check(rd[0], 1'b1);
        set_lv(18'h0);
        wb(0, ERROR_IDX, 0);
        check(rd[0], 1'b0);
        wb(0, IRQ_STAT_IDX, 0);
        check(rd, 32'h4);
        $display("Test status words done");
        wb(1, CMD_IDX, 16'h0100);
        check(dtr_o, 1'b1);
        wb(1, CMD_IDX, 16'h0300);
        check(dtr_o, 1'b0);
        wb(1, CMD_IDX, 16'h0100);
        wb(1, CMD_IDX, 16'h0200);
        check(dtr_o, 1'b0);
        wb(1, OUT_WORD_IDX, 16'h0001);
        check(halt_o, 1'b1);
        wb(1, OUT_WORD_IDX, 16'h0000);
        check(halt_o, 1'b0);
        wb(0, IRQ_STAT_IDX, 0);
        check(rd, 32'hc);
        $display("Test controls done");
        wb(1, OUT_WORD_IDX, 16'hdeac);
        repeat (30) @(posedge clk_i);
        check(rst_cnt, 0);
        wb(1, OUT_WORD_IDX, RESTART_KEY);
        repeat (40) @(posedge clk_i);
        check(rst_cnt, RESTART_CYCLES);
        $display("Test restart done");
        stop_test();
    end

    // Hang guard
    initial begin
        repeat (20000) @(posedge clk_i);
        errors++;
        stop_test();
    end
endmodule // tb_top
